// *** src/emp_pkg.sv ***
// Package: constants and state encoding for the external memory port
package emp_pkg;
  localparam int EMP_ADDR_W = 24;
  localparam int EMP_DATA_W = 24;
  localparam int EMP_ATTR_N = 4;
  localparam int EMP_CNT_W = 8;
  localparam int EMP_WAIT_STATES_DEF = 1;
  localparam int EMP_REFRESH_CYCLES_DEF = 2;
  localparam logic [EMP_ADDR_W-1:0] EMP_ADDR_RST = 24'h000000;
  localparam logic [EMP_DATA_W-1:0] EMP_DATA_RST = 24'h000000;
  localparam logic [EMP_CNT_W-1:0] EMP_CNT_RST = 8'h00;
  localparam logic [EMP_CNT_W-1:0] EMP_CNT_ONE = 8'h01;
  localparam logic [EMP_ATTR_N-1:0] EMP_ATTR_ALL = 4'hF;

  typedef enum logic [2:0]
  {
    EMP_IDLE = 3'b000,
    EMP_SETUP = 3'b001,
    EMP_STROBE = 3'b010,
    EMP_DONE = 3'b011,
    EMP_REFRESH = 3'b100
  } emp_state_e;
endpackage

// *** src/emp_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module emp_sync
  import emp_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule

// *** src/emp_attr_cell.sv ***
// One attribute / row strobe output line
`timescale 1ns/10ps
module emp_attr_cell
  import emp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic acc_active,
  input wire logic row_active,
  input wire logic dram_mode,
  input wire logic as_addr,
  input wire logic addr_bit,
  input wire logic sel,
  input wire logic active_high,
  // Pin level
  output logic pin_level
);
  logic lvl;
  logic pin_q;
  logic pin_d;

  always_comb
  begin
    if (dram_mode)
      lvl = row_active & sel;
    else if (as_addr)
      lvl = acc_active & addr_bit;
    else
      lvl = acc_active & sel;
    // Inactive level is restored as soon as the cycle ends
    pin_d = active_high ? lvl : ~lvl;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      pin_q <= 1'b1;
    else
      pin_q <= pin_d;
  end

  assign pin_level = pin_q;
endmodule

// *** src/emp_port.sv ***
// External memory expansion port: pin drivers, access sequencer, stand-by release
`timescale 1ns/10ps
module emp_port
  import emp_pkg::*;
#(
  parameter int WAIT_STATES = EMP_WAIT_STATES_DEF,
  parameter int REFRESH_CYCLES = EMP_REFRESH_CYCLES_DEF
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Core access request
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic [EMP_ADDR_W-1:0] acc_addr,
  input wire logic [EMP_DATA_W-1:0] acc_wdata,
  input wire logic [EMP_ATTR_N-1:0] acc_attr_sel,
  input wire logic [EMP_ATTR_N-1:0] acc_attr_addr,
  output logic acc_ready,
  output logic acc_done,
  output logic [EMP_DATA_W-1:0] acc_rdata,
  // Configuration and power modes
  input wire logic [EMP_ATTR_N-1:0] attr_active_high,
  input wire logic [EMP_ATTR_N-1:0] attr_as_addr,
  input wire logic dram_mode,
  input wire logic refresh_en,
  input wire logic refresh_tick,
  input wire logic stop_mode,
  input wire logic wait_mode,
  // Arbitration pin
  input wire logic bus_grant_n_pin,
  // Address pins
  output logic [EMP_ADDR_W-1:0] addr_out,
  output logic addr_oe,
  // Data pins
  input wire logic [EMP_DATA_W-1:0] data_in_pin,
  output logic [EMP_DATA_W-1:0] data_out,
  output logic data_oe,
  // Attribute / row strobe pins
  output logic [EMP_ATTR_N-1:0] attr_or_row_strobe,
  output logic attr_oe,
  // Strobe and control pins
  output logic rd_n,
  output logic rd_oe,
  output logic wr_n,
  output logic wr_oe,
  output logic bus_busy_line_n,
  output logic bus_busy_oe,
  output logic cas_n,
  output logic cas_oe,
  output logic bclk,
  output logic bclk_n,
  output logic bclk_oe
);
  localparam logic [EMP_CNT_W-1:0] STROBE_LEN = EMP_CNT_W'(WAIT_STATES + 1);
  localparam logic [EMP_CNT_W-1:0] REFRESH_LEN = EMP_CNT_W'(REFRESH_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers
  logic grant_n_s;
  logic [EMP_DATA_W-1:0] data_in_s;

  emp_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_grant
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(bus_grant_n_pin),
    .dout(grant_n_s)
  );

  emp_sync #(.WIDTH(EMP_DATA_W), .RST_VAL(EMP_DATA_RST)) u_sync_data
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(data_in_pin),
    .dout(data_in_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  emp_state_e state_q;
  emp_state_e state_d;
  logic [EMP_CNT_W-1:0] cnt_q;
  logic [EMP_CNT_W-1:0] cnt_d;
  logic master_q;
  logic master_d;
  logic refr_pend_q;
  logic refr_pend_d;
  logic write_q;
  logic write_d;
  logic [EMP_ADDR_W-1:0] addr_q;
  logic [EMP_ADDR_W-1:0] addr_d;
  logic [EMP_DATA_W-1:0] wdata_q;
  logic [EMP_DATA_W-1:0] wdata_d;
  logic [EMP_DATA_W-1:0] rdata_q;
  logic [EMP_DATA_W-1:0] rdata_d;
  logic [EMP_ATTR_N-1:0] sel_q;
  logic [EMP_ATTR_N-1:0] sel_d;
  logic [EMP_ATTR_N-1:0] xaddr_q;
  logic [EMP_ATTR_N-1:0] xaddr_d;
  logic done_q;
  logic done_d;
  logic rd_n_q;
  logic rd_n_d;
  logic wr_n_q;
  logic wr_n_d;
  logic cas_n_q;
  logic cas_n_d;
  logic bclk_q;
  logic bclk_d;
  logic standby;
  logic in_cycle;
  logic take;
  logic refr_go;

  always_comb
  begin
    standby = stop_mode | wait_mode;
    in_cycle = (state_q != EMP_IDLE);
    take = acc_req & acc_ready;
    refr_go = (state_q == EMP_IDLE) & master_q & refr_pend_q & ~take;
    state_d = state_q;
    cnt_d = cnt_q;
    write_d = write_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    sel_d = sel_q;
    xaddr_d = xaddr_q;
    done_d = 1'b0;
    rd_n_d = 1'b1;
    wr_n_d = 1'b1;
    cas_n_d = 1'b1;
    bclk_d = master_q ? ~bclk_q : 1'b0;
    // New tick wins over the clear when refresh starts
    refr_pend_d = (refr_pend_q & ~refr_go) | (refresh_tick & refresh_en & dram_mode);
    // A running cycle always finishes before the bus is given up
    if (in_cycle)
      master_d = 1'b1;
    else if (stop_mode)
      master_d = 1'b0;
    else if (wait_mode)
      master_d = ~grant_n_s & refresh_en & refr_pend_q;
    else
      master_d = ~grant_n_s;
    case (state_q)
      EMP_IDLE:
      begin
        if (take)
        begin
          state_d = EMP_SETUP;
          write_d = acc_write;
          addr_d = acc_addr;
          wdata_d = acc_wdata;
          sel_d = acc_attr_sel;
          xaddr_d = acc_attr_addr;
        end
        else if (refr_go)
        begin
          state_d = EMP_REFRESH;
          cnt_d = REFRESH_LEN;
          cas_n_d = 1'b0;
        end
      end
      EMP_SETUP:
      begin
        state_d = EMP_STROBE;
        cnt_d = STROBE_LEN;
        rd_n_d = write_q;
        wr_n_d = ~write_q;
        cas_n_d = ~dram_mode;
      end
      EMP_STROBE:
      begin
        if (cnt_q == EMP_CNT_ONE)
          state_d = EMP_DONE;
        else
        begin
          cnt_d = cnt_q - EMP_CNT_ONE;
          rd_n_d = write_q;
          wr_n_d = ~write_q;
          cas_n_d = ~dram_mode;
        end
      end
      EMP_DONE:
      begin
        state_d = EMP_IDLE;
        done_d = 1'b1;
        if (!write_q)
          rdata_d = data_in_s;
      end
      EMP_REFRESH:
      begin
        // Column strobe leads the row strobes for a refresh cycle
        if (cnt_q == EMP_CNT_ONE)
          state_d = EMP_IDLE;
        else
        begin
          cnt_d = cnt_q - EMP_CNT_ONE;
          cas_n_d = 1'b0;
        end
      end
      default:
      begin
        state_d = EMP_IDLE;
        cnt_d = EMP_CNT_RST;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q <= EMP_IDLE;
      cnt_q <= EMP_CNT_RST;
      master_q <= 1'b0;
      refr_pend_q <= 1'b0;
      write_q <= 1'b0;
      addr_q <= EMP_ADDR_RST;
      wdata_q <= EMP_DATA_RST;
      rdata_q <= EMP_DATA_RST;
      sel_q <= '0;
      xaddr_q <= '0;
      done_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      cas_n_q <= 1'b1;
      bclk_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      master_q <= master_d;
      refr_pend_q <= refr_pend_d;
      write_q <= write_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      sel_q <= sel_d;
      xaddr_q <= xaddr_d;
      done_q <= done_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      cas_n_q <= cas_n_d;
      bclk_q <= bclk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Attribute / row strobe lines
  logic acc_phase;
  logic row_phase;
  logic [EMP_ATTR_N-1:0] row_sel;

  always_comb
  begin
    acc_phase = (state_d == EMP_SETUP) | (state_d == EMP_STROBE);
    row_phase = acc_phase | (state_q == EMP_REFRESH);
    row_sel = (state_q == EMP_REFRESH) ? EMP_ATTR_ALL : sel_d;
  end

  for (genvar i = 0; i < EMP_ATTR_N; i++)
  begin : g_attr
    emp_attr_cell u_cell
    (
      .ref_clk(ref_clk),
      .rst(rst),
      .acc_active(acc_phase),
      .row_active(row_phase),
      .dram_mode(dram_mode),
      .as_addr(attr_as_addr[i]),
      .addr_bit(xaddr_d[i]),
      .sel(row_sel[i]),
      .active_high(attr_active_high[i]),
      .pin_level(attr_or_row_strobe[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive; every enable except data_oe follows the one mastership flag
  always_comb
  begin
    acc_ready = (state_q == EMP_IDLE) & master_q & ~standby;
    acc_done = done_q;
    acc_rdata = rdata_q;
    addr_out = addr_q;
    addr_oe = master_q;
    data_out = wdata_q;
    data_oe = master_q & write_q & in_cycle & (state_q != EMP_REFRESH);
    attr_oe = master_q;
    rd_n = rd_n_q;
    rd_oe = master_q;
    wr_n = wr_n_q;
    wr_oe = master_q;
    bus_busy_line_n = ~master_q;
    bus_busy_oe = master_q;
    cas_n = cas_n_q;
    cas_oe = master_q;
    bclk = bclk_q;
    bclk_n = ~bclk_q;
    bclk_oe = master_q;
  end
endmodule

// *** tb/emp_port_checker.sv ***
// Checker: port timing and tri-state properties of the memory port
`timescale 1ns/10ps
module emp_port_checker
  import emp_pkg::*;
#(
  parameter int WAIT_STATES = 1
)
(
  // Clock and reset
  input wire logic ref_clk, rst,
  // Core side and modes
  input wire logic acc_req, acc_ready, acc_done, dram_mode, stop_mode,
  input wire logic [EMP_ADDR_W-1:0] acc_addr, addr_out,
  input wire logic [EMP_ATTR_N-1:0] attr_active_high, attr_as_addr, attr_or_row_strobe,
  // Enables and strobes
  input wire logic addr_oe, data_oe, attr_oe, rd_n, rd_oe, wr_n, wr_oe,
  input wire logic cas_n, cas_oe, bus_busy_oe, bclk_oe
);
  localparam int DONE_LAT = 4 + WAIT_STATES;
  wire take = acc_req && acc_ready;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_addr_on_take: assert property (take |=> addr_out == $past(acc_addr))
    else $error("address not driven after take");
  a_done_latency: assert property (take |-> ##DONE_LAT acc_done)
    else $error("access not done in time");
  // Address moves only on a new access, saving pin power
  a_addr_hold: assert property ($changed(addr_out) |-> $past(take))
    else $error("address changed without access");
  a_oe_group: assert property (attr_oe == addr_oe && rd_oe == addr_oe && wr_oe == addr_oe
    && cas_oe == addr_oe && bus_busy_oe == addr_oe && bclk_oe == addr_oe)
    else $error("enables disagree");
  a_reset_release: assert property (disable iff (1'b0) rst |=> !addr_oe && !data_oe)
    else $error("pins driven in reset");
  a_data_oe_write: assert property (data_oe |-> addr_oe && rd_n)
    else $error("data driven outside write");
  a_rd_master: assert property (!rd_n |-> rd_oe && wr_n)
    else $error("read strobe without mastership");
  a_wr_master: assert property (!wr_n |-> wr_oe && data_oe)
    else $error("write strobe without data drive");
  a_attr_release: assert property (acc_done |-> ((attr_or_row_strobe ^ attr_active_high) | attr_as_addr)
    == EMP_ATTR_ALL)
    else $error("attribute line still active");
  a_stop_release: assert property (stop_mode [*8] |-> !addr_oe)
    else $error("bus kept in stop");
  a_ready_standby: assert property (acc_ready |-> !stop_mode)
    else $error("ready during stop");
  a_cas_dram: assert property ($fell(rd_n) && dram_mode |-> !cas_n)
    else $error("no column strobe in dram read");
  c_dram_take: cover property (take && dram_mode);
  c_stop_master: cover property (stop_mode && addr_oe);
  c_refresh: cover property (!cas_n && rd_n && wr_n);
endmodule
bind emp_port emp_port_checker #(.WAIT_STATES(WAIT_STATES)) i_emp_port_checker (.ref_clk, .rst, .acc_req,
  .acc_ready, .acc_done, .dram_mode, .stop_mode, .acc_addr, .addr_out, .attr_active_high, .attr_as_addr,
  .attr_or_row_strobe, .addr_oe, .data_oe, .attr_oe, .rd_n, .rd_oe, .wr_n, .wr_oe, .cas_n, .cas_oe,
  .bus_busy_oe, .bclk_oe);

// *** tb/emp_mem.sv ***
// Partner model: external static memory on the shared bus
`timescale 1ns/10ps
module emp_mem
  import emp_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Bus from the port
  input wire logic [EMP_ADDR_W-1:0] addr_out,
  input wire logic [EMP_DATA_W-1:0] data_out,
  input wire logic data_oe, rd_n, rd_oe, wr_n, wr_oe,
  // Data back to the port
  output logic [EMP_DATA_W-1:0] data_in_pin
);
  logic [EMP_DATA_W-1:0] mem_q [logic [EMP_ADDR_W-1:0]];
  logic [EMP_DATA_W-1:0] last_q;
  initial
  begin
    last_q = EMP_DATA_RST;
    data_in_pin = EMP_DATA_RST;
  end
  always @(posedge ref_clk)
    if (wr_oe && !wr_n && data_oe)
      mem_q[addr_out] = data_out;
  // Released bus shows the inverted word, never the stale one
  always @(addr_out, rd_n, rd_oe)
    if (rd_oe && !rd_n && mem_q.exists(addr_out))
    begin
      data_in_pin = mem_q[addr_out];
      last_q = data_in_pin;
    end
    else
      data_in_pin = ~last_q;
endmodule

// *** tb/emp_port_bench.sv ***
// Testbench: table of accesses, tri-state, stand-by and refresh
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("Error at %0t: got %h exp %h", $time, g, e); end end
module emp_port_bench
  import emp_pkg::*;
;
  typedef struct packed {logic w; logic [23:0] a; logic [23:0] d; logic [3:0] sel; logic [3:0] pol; logic [3:0] asa;} emp_row_s;
  logic ref_clk, rst, acc_req, acc_write, dram_mode, refresh_en, refresh_tick, stop_mode, wait_mode, bus_grant_n_pin;
  logic [EMP_ADDR_W-1:0] acc_addr, addr_out;
  logic [EMP_DATA_W-1:0] acc_wdata, acc_rdata, data_in_pin, data_out;
  logic [EMP_ATTR_N-1:0] acc_attr_sel, acc_attr_addr, attr_active_high, attr_as_addr, attr_or_row_strobe;
  logic acc_ready, acc_done, addr_oe, data_oe, attr_oe, rd_n, rd_oe, wr_n, wr_oe;
  logic bus_busy_line_n, bus_busy_oe, cas_n, cas_oe, bclk, bclk_n, bclk_oe, seen;
  int failures, checked, i, n;
  emp_row_s rows [6] = '{'{1, 24'h000010, 24'hA5A5A5, 4'h1, 4'h0, 4'h0},
    '{1, 24'hFFFFFF, 24'h123456, 4'h3, 4'h0, 4'h0}, '{0, 24'h000010, 24'hA5A5A5, 4'h1, 4'h0, 4'h0},
    '{0, 24'hFFFFFF, 24'h123456, 4'hC, 4'h5, 4'h8}, '{1, 24'h800001, 24'hFFFFFF, 4'hF, 4'hF, 4'h0},
    '{0, 24'h800001, 24'hFFFFFF, 4'h6, 4'hA, 4'h2}};
  emp_port #(.WAIT_STATES(1), .REFRESH_CYCLES(EMP_REFRESH_CYCLES_DEF)) i_emp_port (.ref_clk, .rst, .acc_req,
    .acc_write, .acc_addr,
    .acc_wdata, .acc_attr_sel, .acc_attr_addr, .acc_ready, .acc_done, .acc_rdata, .attr_active_high,
    .attr_as_addr, .dram_mode, .refresh_en, .refresh_tick, .stop_mode, .wait_mode, .bus_grant_n_pin,
    .addr_out, .addr_oe, .data_in_pin, .data_out, .data_oe, .attr_or_row_strobe, .attr_oe, .rd_n, .rd_oe,
    .wr_n, .wr_oe, .bus_busy_line_n, .bus_busy_oe, .cas_n, .cas_oe, .bclk, .bclk_n, .bclk_oe);
  emp_mem i_emp_mem (.ref_clk, .addr_out, .data_out, .data_oe, .rd_n, .rd_oe, .wr_n, .wr_oe, .data_in_pin);
  ////////////////////////////////////////
  initial
  begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic test_done;
    $display("Checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Config only changes off the done cycle, so the release check sees steady polarity
  task automatic acc(input emp_row_s r);
    if ({r.pol, r.asa} !== {attr_active_high, attr_as_addr})
      step(1);
    for (n = 0; n < 20 && acc_ready !== 1'b1; n++)
      step(1);
    `CHK(acc_ready, 1'b1)
    {acc_req, acc_write, acc_addr, acc_wdata, acc_attr_sel, attr_active_high, attr_as_addr} = {1'b1, r};
    // Extra address bits differ from the selects, so address-mode lines show their own value
    acc_attr_addr = ~r.sel;
    step(1);
    acc_req = 0;
    step(1);
    `CHK(addr_out, r.a)
    `CHK({rd_n, wr_n, data_oe}, {r.w, !r.w, r.w})
    `CHK(attr_or_row_strobe, r.pol ~^ (r.sel ^ r.asa))
    step(2);
    `CHK({rd_n, wr_n}, 2'b11)
    `CHK(attr_or_row_strobe ^ r.pol, EMP_ATTR_ALL)
    step(1);
    `CHK(acc_done, 1'b1)
    if (!r.w)
      `CHK(acc_rdata, r.d)
  endtask
  initial
  begin
    step(2000);
    failures++;
    $display("Error at %0t: timeout", $time);
    test_done;
  end
  initial
  begin
    {rst, acc_req, acc_write, dram_mode, refresh_en, refresh_tick, stop_mode, wait_mode} = 8'h80;
    {bus_grant_n_pin, acc_addr, acc_wdata, acc_attr_sel, acc_attr_addr} = 57'h1_0000_0000_0000_00;
    {attr_active_high, attr_as_addr, failures, checked} = 0;
    step(6);
    `CHK({addr_oe, data_oe, attr_oe, rd_oe, wr_oe, bus_busy_oe, cas_oe, bclk_oe}, 8'h00)
    `CHK({rd_n, wr_n, acc_ready, bclk, bus_busy_line_n}, 5'b11001)
    rst = 0;
    bus_grant_n_pin = 0;
    $display("Test reset done");
    for (i = 0; i < 6; i++)
      acc(rows[i]);
    $display("Test table done");
    step(10);
    `CHK({addr_out, rd_n, wr_n, addr_oe}, {24'h800001, 3'b111})
    `CHK({bus_busy_line_n, bclk ^ bclk_n}, 2'b01)
    seen = bclk;
    step(1);
    `CHK(bclk, !seen)
    bus_grant_n_pin = 1;
    step(6);
    `CHK({addr_oe, data_oe, rd_oe, wr_oe, attr_oe}, 5'h00)
    bus_grant_n_pin = 0;
    step(6);
    stop_mode = 1;
    // Held long enough for the stop release property to see its full window
    step(8);
    `CHK({addr_oe, attr_oe, cas_oe, bus_busy_oe, bclk_oe}, 5'h00)
    stop_mode = 0;
    $display("Test release done");
    dram_mode = 1;
    acc('{0, 24'h000010, 24'hA5A5A5, 4'h2, 4'hF, 4'h0});
    {refresh_en, wait_mode} = 2'b11;
    step(3);
    `CHK(addr_oe, 1'b0)
    refresh_tick = 1;
    step(1);
    refresh_tick = 0;
    seen = 0;
    for (n = 0; n < 20; n++)
    begin
      step(1);
      seen |= addr_oe && !cas_n && attr_or_row_strobe === 4'hF;
    end
    `CHK({seen, addr_oe}, 2'b10)
    $display("Test refresh done");
    test_done;
  end
endmodule
